/* File: logic/ttu_counter.sv */
// reloadable 8-bit down-counter with underflow pulse
`timescale 1ns/100ps
`default_nettype none
module ttu_counter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       cnt_en,
    input  wire logic [7:0] latch,
    output logic      [7:0] value,
    output logic            underflow
);
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;

    always_comb begin
        nxt_cnt   = cnt_ff;
        underflow = 1'b0;
        if (cnt_en) begin
            if (cnt_ff == 8'h00) begin
                nxt_cnt   = latch; // R1 R2
                underflow = 1'b1;
            end else begin
                nxt_cnt = cnt_ff - 8'h01; // R2
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 8'hff;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign value = cnt_ff;
endmodule // ttu_counter
`default_nettype wire

/* File: logic/ttu_pkg.sv */
// package of constants for the three timer unit
package ttu_pkg;
    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] ADDR_PRE_LATCH = 8'h00;
    localparam logic [7:0] ADDR_T1_LATCH  = 8'h04;
    localparam logic [7:0] ADDR_T2_LATCH  = 8'h08;
    localparam logic [7:0] ADDR_TX_LATCH  = 8'h0c;
    localparam logic [7:0] ADDR_TX_MODE   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;
    localparam logic [7:0] ADDR_PRE_CNT   = 8'h1c;
    localparam logic [7:0] ADDR_T1_CNT    = 8'h20;
    localparam logic [7:0] ADDR_T2_CNT    = 8'h24;
    localparam logic [7:0] ADDR_TX_CNT    = 8'h28;
    // ****************************************
    // mode register fields
    // ****************************************
    localparam int MODE_LSB  = 0;
    localparam int SRC_BIT   = 2;
    localparam int EDGE_BIT  = 3;
    localparam int STOP_BIT  = 4;
    localparam logic [1:0] MODE_TIMER = 2'h0;
    localparam logic [1:0] MODE_PULSE = 2'h1;
    localparam logic [1:0] MODE_EVENT = 2'h2;
    localparam logic [1:0] MODE_WIDTH = 2'h3;
    // ****************************************
    // status bit positions and reset values
    // ****************************************
    localparam int IRQ_T1 = 0;
    localparam int IRQ_T2 = 1;
    localparam int IRQ_TX = 2;
    localparam int IRQ_EV = 3;
    localparam logic [7:0] RST_PRE_LATCH = 8'hff;
    localparam logic [7:0] RST_T1_LATCH  = 8'h01;
    localparam logic [7:0] RST_T2_LATCH  = 8'hff;
    localparam logic [7:0] RST_TX_LATCH  = 8'hff;
    localparam logic [4:0] RST_TX_MODE   = 5'h10;
    // ****************************************
    // timing: oscillator input = REF_CLK, divided by sixteen
    // ****************************************
    localparam int OSC_DIV   = 16;
    localparam int FAST_DIV  = 2;
endpackage

/* File: logic/ttu_top.sv */
// three timer unit: prescaler, two periodic timers, multi-mode timer, apb registers
// What this block does
// R1 - each counter divides its count pulses by latch value plus one
// R2 - counters count down; count pulse at zero underflows and reloads latch
// R3 - each timer underflow sets that timer's interrupt request bit; prescaler underflow sets none
// R4 - prescaler always counts oscillator input divided by sixteen
// R5 - both periodic timers always count the prescaler output
// R6 - multi-mode timer has timer, pulse, event, width modes
// R7 - timer mode counts the selected internal source
// R8 - pulse mode toggles event pin each time count reaches zero
// R9 - pulse output starts high for edge bit zero, low for one
// R10 - EVENT_PIN_OE sets the shared port pin as output whenever mode is pulse
// R11 - event mode counts rising edges, or falling with edge bit one
// R12 - width mode counts source while pin high, or low with bit one
// R13 - count stop bit one holds the count in every mode
// R14 - event pin synchronised, edges become single-cycle enables
`timescale 1ns/100ps
`default_nettype none
module ttu_top (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EVENT_PIN_IN,
    output logic             EVENT_PIN_OUT,
    output logic             EVENT_PIN_OE,
    output logic             IRQ
);
    // ****************************************
    // state
    // ****************************************
    logic [7:0]  pre_latch_ff, nxt_pre_latch;
    logic [7:0]  t1_latch_ff,  nxt_t1_latch;
    logic [7:0]  t2_latch_ff,  nxt_t2_latch;
    logic [7:0]  tx_latch_ff,  nxt_tx_latch;
    logic [4:0]  tx_mode_ff,   nxt_tx_mode;
    logic [3:0]  stat_ff,      nxt_stat;
    logic [3:0]  mask_ff,      nxt_mask;
    logic [31:0] rdata_ff,     nxt_rdata;
    logic        slverr_ff,    nxt_slverr;
    logic [3:0]  osc_div_ff,   nxt_osc_div;
    logic        fast_div_ff,  nxt_fast_div;
    logic [2:0]  sync_ff,      nxt_sync;
    logic        pin_lvl_ff,   nxt_pin_lvl;
    logic        pulse_ff,     nxt_pulse;
    logic [1:0]  prev_mode_ff, nxt_prev_mode;

    logic        osc_tick, fast_tick, src_tick;
    logic        pre_uf, t1_uf, t2_uf, tx_uf;
    logic        tx_en, ev_edge, wr_en, rd_en, addr_ok;
    logic [7:0]  pre_val, t1_val, t2_val, tx_val;
    logic [1:0]  mode;
    logic        edge_sel, stop, src_sel;
    logic [3:0]  events;

    assign mode     = tx_mode_ff[ttu_pkg::MODE_LSB +: 2];
    assign src_sel  = tx_mode_ff[ttu_pkg::SRC_BIT];
    assign edge_sel = tx_mode_ff[ttu_pkg::EDGE_BIT];
    assign stop     = tx_mode_ff[ttu_pkg::STOP_BIT];

    // ****************************************
    // clock dividers: oscillator/16 and fast source
    // ****************************************
    always_comb begin
        nxt_osc_div  = osc_div_ff + 4'h1;
        osc_tick     = (osc_div_ff == 4'(ttu_pkg::OSC_DIV - 1)); // R4
        nxt_fast_div = ~fast_div_ff;
        fast_tick    = fast_div_ff == 1'(ttu_pkg::FAST_DIV - 1);
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            osc_div_ff  <= 4'h0;
            fast_div_ff <= 1'b0;
        end else begin
            osc_div_ff  <= nxt_osc_div;
            fast_div_ff <= nxt_fast_div;
        end
    end

    // ****************************************
    // event pin synchroniser and edge detection
    // ****************************************
    always_comb begin
        nxt_sync    = {sync_ff[1:0], EVENT_PIN_IN};
        nxt_pin_lvl = pin_lvl_ff;
        ev_edge     = 1'b0;
        // a level counts once the second and third stages agree
        if (sync_ff[1] == sync_ff[2]) begin
            nxt_pin_lvl = sync_ff[2]; // R14
            if (sync_ff[2] != pin_lvl_ff) begin
                ev_edge = (sync_ff[2] != edge_sel); // R11 R14
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync_ff    <= 3'h0;
            pin_lvl_ff <= 1'b0;
        end else begin
            sync_ff    <= nxt_sync;
            pin_lvl_ff <= nxt_pin_lvl;
        end
    end

    // ****************************************
    // counters
    // ****************************************
    // fast source is REF_CLK/2, else prescaler underflow
    assign src_tick = src_sel ? fast_tick : pre_uf;

    always_comb begin
        tx_en = 1'b0;
        case (mode)
            ttu_pkg::MODE_TIMER: tx_en = src_tick; // R6 R7
            ttu_pkg::MODE_PULSE: tx_en = src_tick; // R8
            ttu_pkg::MODE_EVENT: tx_en = ev_edge;  // R11
            ttu_pkg::MODE_WIDTH: tx_en = src_tick && (pin_lvl_ff != edge_sel); // R12
            default:             tx_en = 1'b0;
        endcase
        if (stop) begin
            tx_en = 1'b0; // R13
        end
    end

    ttu_counter u_pre (
        .clk       (REF_CLK),
        .rst_n     (RSTN),
        .cnt_en    (osc_tick), // R4
        .latch     (pre_latch_ff),
        .value     (pre_val),
        .underflow (pre_uf)
    );

    ttu_counter u_t1 (
        .clk       (REF_CLK),
        .rst_n     (RSTN),
        .cnt_en    (pre_uf), // R5
        .latch     (t1_latch_ff),
        .value     (t1_val),
        .underflow (t1_uf)
    );

    ttu_counter u_t2 (
        .clk       (REF_CLK),
        .rst_n     (RSTN),
        .cnt_en    (pre_uf), // R5
        .latch     (t2_latch_ff),
        .value     (t2_val),
        .underflow (t2_uf)
    );

    ttu_counter u_tx (
        .clk       (REF_CLK),
        .rst_n     (RSTN),
        .cnt_en    (tx_en),
        .latch     (tx_latch_ff),
        .value     (tx_val),
        .underflow (tx_uf)
    );

    // ****************************************
    // pulse output
    // ****************************************
    always_comb begin
        nxt_prev_mode = mode;
        nxt_pulse     = pulse_ff;
        if (mode != ttu_pkg::MODE_PULSE || prev_mode_ff != ttu_pkg::MODE_PULSE) begin
            nxt_pulse = ~edge_sel; // R9
        end else if (tx_en && tx_val == 8'h01) begin
            nxt_pulse = ~pulse_ff; // R8
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pulse_ff     <= 1'b1;
            prev_mode_ff <= ttu_pkg::MODE_TIMER;
        end else begin
            pulse_ff     <= nxt_pulse;
            prev_mode_ff <= nxt_prev_mode;
        end
    end
    // pin direction is driven here from the mode: output only in pulse mode
    assign EVENT_PIN_OE  = (mode == ttu_pkg::MODE_PULSE); // R10
    assign EVENT_PIN_OUT = pulse_ff;

    // ****************************************
    // apb slave and interrupts
    // ****************************************
    assign wr_en  = PSEL && PENABLE && PWRITE;
    assign rd_en  = PSEL && !PENABLE && !PWRITE;
    assign events = {ev_edge && (mode == ttu_pkg::MODE_EVENT), tx_uf, t2_uf, t1_uf};

    always_comb begin
        case (PADDR)
            ttu_pkg::ADDR_PRE_LATCH, ttu_pkg::ADDR_T1_LATCH, ttu_pkg::ADDR_T2_LATCH,
            ttu_pkg::ADDR_TX_LATCH, ttu_pkg::ADDR_TX_MODE, ttu_pkg::ADDR_IRQ_STAT,
            ttu_pkg::ADDR_IRQ_MASK, ttu_pkg::ADDR_PRE_CNT, ttu_pkg::ADDR_T1_CNT,
            ttu_pkg::ADDR_T2_CNT, ttu_pkg::ADDR_TX_CNT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // ****************************************
    // register writes and status
    // ****************************************
    always_comb begin
        nxt_pre_latch = pre_latch_ff;
        nxt_t1_latch  = t1_latch_ff;
        nxt_t2_latch  = t2_latch_ff;
        nxt_tx_latch  = tx_latch_ff;
        nxt_tx_mode   = tx_mode_ff;
        nxt_mask      = mask_ff;
        nxt_stat      = stat_ff;
        // writing a latch leaves the running count alone
        if (wr_en) begin
            case (PADDR)
                ttu_pkg::ADDR_PRE_LATCH: nxt_pre_latch = PWDATA[7:0];
                ttu_pkg::ADDR_T1_LATCH:  nxt_t1_latch  = PWDATA[7:0];
                ttu_pkg::ADDR_T2_LATCH:  nxt_t2_latch  = PWDATA[7:0];
                ttu_pkg::ADDR_TX_LATCH:  nxt_tx_latch  = PWDATA[7:0];
                ttu_pkg::ADDR_TX_MODE:   nxt_tx_mode   = PWDATA[4:0];
                ttu_pkg::ADDR_IRQ_STAT:  nxt_stat      = stat_ff & ~PWDATA[3:0];
                ttu_pkg::ADDR_IRQ_MASK:  nxt_mask      = PWDATA[3:0];
                default:                 nxt_stat      = stat_ff;
            endcase
        end
        // write one clears; an event in the same cycle wins
        nxt_stat = nxt_stat | events; // R3
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_latch_ff <= ttu_pkg::RST_PRE_LATCH;
            t1_latch_ff  <= ttu_pkg::RST_T1_LATCH;
            t2_latch_ff  <= ttu_pkg::RST_T2_LATCH;
            tx_latch_ff  <= ttu_pkg::RST_TX_LATCH;
            tx_mode_ff   <= ttu_pkg::RST_TX_MODE;
            stat_ff      <= 4'h0;
            mask_ff      <= 4'h0;
        end else begin
            pre_latch_ff <= nxt_pre_latch;
            t1_latch_ff  <= nxt_t1_latch;
            t2_latch_ff  <= nxt_t2_latch;
            tx_latch_ff  <= nxt_tx_latch;
            tx_mode_ff   <= nxt_tx_mode;
            stat_ff      <= nxt_stat;
            mask_ff      <= nxt_mask;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        nxt_rdata  = rdata_ff;
        nxt_slverr = slverr_ff;
        if (rd_en) begin
            case (PADDR)
                ttu_pkg::ADDR_PRE_LATCH: nxt_rdata = {24'h000000, pre_latch_ff};
                ttu_pkg::ADDR_T1_LATCH:  nxt_rdata = {24'h000000, t1_latch_ff};
                ttu_pkg::ADDR_T2_LATCH:  nxt_rdata = {24'h000000, t2_latch_ff};
                ttu_pkg::ADDR_TX_LATCH:  nxt_rdata = {24'h000000, tx_latch_ff};
                ttu_pkg::ADDR_TX_MODE:   nxt_rdata = {27'h0000000, tx_mode_ff};
                ttu_pkg::ADDR_IRQ_STAT:  nxt_rdata = {28'h0000000, stat_ff};
                ttu_pkg::ADDR_IRQ_MASK:  nxt_rdata = {28'h0000000, mask_ff};
                ttu_pkg::ADDR_PRE_CNT:   nxt_rdata = {24'h000000, pre_val};
                ttu_pkg::ADDR_T1_CNT:    nxt_rdata = {24'h000000, t1_val};
                ttu_pkg::ADDR_T2_CNT:    nxt_rdata = {24'h000000, t2_val};
                ttu_pkg::ADDR_TX_CNT:    nxt_rdata = {24'h000000, tx_val};
                default:                 nxt_rdata = 32'h00000000;
            endcase
        end
        // error flag is taken in the setup cycle, shown in the access phase
        if (PSEL && !PENABLE) begin
            nxt_slverr = !addr_ok;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_ff  <= 32'h00000000;
            slverr_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            slverr_ff <= nxt_slverr;
        end
    end

    assign PRDATA  = rdata_ff;
    assign PREADY  = 1'b1;
    assign PSLVERR = slverr_ff && PSEL && PENABLE;
    assign IRQ     = |(stat_ff & mask_ff);
endmodule // ttu_top
`default_nettype wire

/* File: verification/three_timer_unit_bench.sv */
// self-checking bench of the three timer unit
`timescale 1ns/100ps
`default_nettype none
module three_timer_unit_bench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  pa = 8'h0;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic        pin;
    logic        eo;
    logic        oe;
    logic        irq;
    logic [32:0] notes [$];
    logic [31:0] rs = 32'hf207acc3;
    logic [7:0]  ra [3];
    int          error_cnt = 0;
    int          compares = 0;
    int          cyc = 0;
    int          e;
    int          i;
    always #2.5 clk = ~clk;
    ttu_top dut (.REF_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .EVENT_PIN_IN(pin), .EVENT_PIN_OUT(eo), .EVENT_PIN_OE(oe), .IRQ(irq));
    ttu_pin_model pm (.clk(clk), .oe(oe), .dout(eo), .pin(pin));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [32:0] x, input logic [32:0] g);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] x);
        if (!w) begin
            notes.push_back(x);
        end
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 32'h0, {25'h0, x});
    endtask
    task automatic md(input logic [1:0] m, input logic s, input logic eb, input logic st);
        wr(ttu_pkg::ADDR_TX_MODE, {27'h0, st, eb, s, m});
    endtask
    task automatic clr();
        wr(ttu_pkg::ADDR_IRQ_STAT, 32'h0000000f);
        @(posedge clk);
    endtask
    task automatic wait_hi();
        while (irq !== 1'b1) @(posedge clk);
    endtask
    task automatic period(input logic [3:0] m, input int x);
        int t0;
        wr(ttu_pkg::ADDR_IRQ_MASK, {28'h0, m});
        repeat (2) begin
            clr();
            wait_hi();
        end
        t0 = cyc;
        clr();
        wait_hi();
        chk("irq period", 33'(x), 33'(cyc - t0));
    endtask
    task automatic pulse(input logic idle);
        pm.put(!idle, 24);
        pm.put(idle, 24);
    endtask
    // ****************************************
    // read result watcher and timeout
    // ****************************************
    always @(posedge clk) begin
        if (psel && pen && prdy && !pwr) begin
            chk("read", (notes.size() > 0) ? notes.pop_front() : 33'h0, {perr, prd});
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        ra = '{ttu_pkg::ADDR_T2_LATCH, ttu_pkg::ADDR_TX_LATCH, ttu_pkg::ADDR_PRE_LATCH};
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(ttu_pkg::ADDR_PRE_LATCH, ttu_pkg::RST_PRE_LATCH);
        rd(ttu_pkg::ADDR_T1_LATCH, ttu_pkg::RST_T1_LATCH);
        rd(ttu_pkg::ADDR_T2_LATCH, ttu_pkg::RST_T2_LATCH);
        rd(ttu_pkg::ADDR_TX_MODE, {3'h0, ttu_pkg::RST_TX_MODE});
        rd(ttu_pkg::ADDR_IRQ_STAT, 8'h00);
        rd(ttu_pkg::ADDR_IRQ_MASK, 8'h00);
        rd(ttu_pkg::ADDR_TX_CNT, 8'hff);
        wr(ttu_pkg::ADDR_T1_CNT, 32'h0);
        rd(ttu_pkg::ADDR_T1_CNT, 8'hff);
        wr(8'h2c, 32'h5);
        apb(1'b0, 8'h2c, 32'h0, {1'b1, 32'h0});
        for (i = 0; i < 3; i++) begin
            rs = xs(rs);
            wr(ra[i], rs);
            rd(ra[i], rs[7:0]);
        end
        wr(ttu_pkg::ADDR_PRE_LATCH, 32'h0);
        wr(ttu_pkg::ADDR_T1_LATCH, 32'h3);
        wr(ttu_pkg::ADDR_T2_LATCH, 32'h1);
        period(4'h1, 64);
        period(4'h2, 32);
        wr(ttu_pkg::ADDR_TX_LATCH, 32'h4);
        md(ttu_pkg::MODE_TIMER, 1'b1, 1'b0, 1'b0);
        period(4'h4, 10);
        md(ttu_pkg::MODE_TIMER, 1'b0, 1'b0, 1'b0);
        period(4'h4, 80);
        md(ttu_pkg::MODE_TIMER, 1'b1, 1'b0, 1'b1);
        clr();
        repeat (40) @(posedge clk);
        chk("stopped irq", 33'h0, 33'(irq));
        for (e = 0; e < 2; e++) begin
            md(ttu_pkg::MODE_TIMER, 1'b1, e[0], 1'b1);
            md(ttu_pkg::MODE_PULSE, 1'b1, e[0], 1'b1);
            chk("pin start", 33'(!e[0]), 33'(eo));
            chk("pin enable", 33'h1, 33'(oe));
            md(ttu_pkg::MODE_PULSE, 1'b1, e[0], 1'b0);
            while (eo === !e[0]) @(posedge clk);
            i = cyc;
            while (eo === e[0]) @(posedge clk);
            chk("toggle gap", 33'h0a, 33'(cyc - i));
        end
        for (e = 0; e < 2; e++) begin
            wr(ttu_pkg::ADDR_TX_LATCH, 32'h2);
            pm.put(e[0], 2);
            md(ttu_pkg::MODE_EVENT, 1'b0, e[0], 1'b0);
            clr();
            for (i = 0; i < 12 && irq !== 1'b1; i++) pulse(e[0]);
            clr();
            pulse(e[0]);
            pulse(e[0]);
            chk("edge count", 33'h0, 33'(irq));
            pm.put(!e[0], 12);
            chk("edge count", 33'h1, 33'(irq));
            pm.put(e[0], 24);
        end
        wr(ttu_pkg::ADDR_TX_LATCH, 32'h4);
        for (e = 0; e < 2; e++) begin
            pm.put(!e[0], 2);
            md(ttu_pkg::MODE_WIDTH, 1'b1, e[0], 1'b0);
            period(4'h4, 10);
            pm.put(e[0], 2);
            clr();
            pm.put(e[0], 60);
            chk("width hold", 33'h0, 33'(irq));
        end
        stop_test();
    end
endmodule // three_timer_unit_bench
`default_nettype wire

/* File: verification/ttu_chk.sv */
// port checker for the three timer unit and its bind
`timescale 1ns/100ps
`default_nettype none
module ttu_chk (
    input wire logic        REF_CLK,
    input wire logic        RSTN,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        EVENT_PIN_IN,
    input wire logic        EVENT_PIN_OUT,
    input wire logic        EVENT_PIN_OE,
    input wire logic        IRQ
);
    // ****************************************
    // shadow of mode and mask writes
    // ****************************************
    logic [4:0] mode_ff;
    logic [4:0] nxt_mode;
    logic [3:0] mask_ff;
    logic [3:0] nxt_mask;
    logic       acc;
    assign acc = PSEL && PENABLE && PREADY;
    always_comb begin
        nxt_mode = mode_ff;
        nxt_mask = mask_ff;
        if (acc && PWRITE && PADDR == ttu_pkg::ADDR_TX_MODE) begin
            nxt_mode = PWDATA[4:0];
        end
        if (acc && PWRITE && PADDR == ttu_pkg::ADDR_IRQ_MASK) begin
            nxt_mask = PWDATA[3:0];
        end
    end
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mode_ff <= ttu_pkg::RST_TX_MODE;
            mask_ff <= 4'h0;
        end else begin
            mode_ff <= nxt_mode;
            mask_ff <= nxt_mask;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    slverr_map_a: assert property (PSEL && PENABLE |->
        PSLVERR == (PADDR > ttu_pkg::ADDR_TX_CNT || PADDR[1:0] != 2'h0)) else $error("slverr wrong");
    upper_zero_a: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    mode_read_a: assert property (acc && !PWRITE && PADDR == ttu_pkg::ADDR_TX_MODE
        |-> PRDATA[4:0] == mode_ff) else $error("mode readback wrong");
    pin_dir_a: assert property (EVENT_PIN_OE == (mode_ff[1:0] == ttu_pkg::MODE_PULSE))
        else $error("pin direction wrong");
    idle_level_a: assert property (mode_ff == $past(mode_ff) && mode_ff == $past(mode_ff, 2)
        && mode_ff[1:0] != ttu_pkg::MODE_PULSE |-> EVENT_PIN_OUT == !mode_ff[ttu_pkg::EDGE_BIT])
        else $error("pin start level wrong");
    stop_hold_a: assert property (mode_ff == $past(mode_ff) && mode_ff == $past(mode_ff, 2)
        && mode_ff[1:0] == ttu_pkg::MODE_PULSE && mode_ff[ttu_pkg::STOP_BIT]
        |-> $stable(EVENT_PIN_OUT)) else $error("stopped pin toggled");
    toggle_gap_a: assert property (mode_ff == $past(mode_ff, 2) && $changed(EVENT_PIN_OUT)
        && EVENT_PIN_OE && $past(EVENT_PIN_OE) |=> $stable(EVENT_PIN_OUT))
        else $error("toggles too close");
    irq_mask_a: assert property (mask_ff == 4'h0 && $past(mask_ff) == 4'h0 |-> !IRQ)
        else $error("irq with zero mask");
endmodule // ttu_chk
bind ttu_top ttu_chk chk_i (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EVENT_PIN_IN(EVENT_PIN_IN), .EVENT_PIN_OUT(EVENT_PIN_OUT),
    .EVENT_PIN_OE(EVENT_PIN_OE), .IRQ(IRQ));
`default_nettype wire

/* File: verification/ttu_pin_model.sv */
// pulse source and load on the event pin
`timescale 1ns/100ps
`default_nettype none
module ttu_pin_model (
    input  wire logic clk,
    input  wire logic oe,
    input  wire logic dout,
    output logic      pin
);
    logic lvl = 1'b0;
    // source drives only while the device leaves the pin as input
    assign pin = oe ? dout : lvl;
    // level change right after an edge, held for cyc cycles
    task automatic put(input logic v, input int cyc);
        @(posedge clk);
        lvl <= v;
        repeat (cyc - 1) @(posedge clk);
    endtask
endmodule // ttu_pin_model
`default_nettype wire
